// >>> design/seoc_core.sv
// serial eeprom with eight programmable outputs in four pairs
// assumes host pins and output pad levels are asynchronous and are synchronised here
`timescale 1ns/10ps
module seoc_core (
  // clock and reset (reset stands for power-up)
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  // serial port
  input  wire logic        serial_clock_line_i,
  input  wire logic        chip_select_i,
  input  wire logic        serial_in_pin_i,
  output logic             serial_out_o,
  // programmable output pins
  input  wire logic [7:0]  out_pin_i,
  output logic [7:0]       out_pin_o,
  output logic [7:0]       out_pin_oe_o,
  output logic [3:0]       analog_switch_closed_o
);

  // ==========================================================================
  // pair decode
  function automatic seoc_pkg::seoc_pair_s pair_drive(input logic [3:0] m, input logic a_in, input logic b_in);
    seoc_pkg::seoc_pair_s p;
    p = '0;
    case (m)
      4'h0, 4'h1, 4'h2, 4'h3: begin
        p.a    = m[1];
        p.b    = m[0];
        p.a_oe = 1'b1;
        p.b_oe = 1'b1;
      end
      4'h4, 4'h7: begin
        p.a    = m[0];
        p.a_oe = 1'b1;
      end
      4'h5, 4'h6: begin
        p.a    = b_in ^ m[1];
        p.a_oe = 1'b1;
      end
      4'h8, 4'hB: begin
        p.b    = m[0];
        p.b_oe = 1'b1;
      end
      4'h9, 4'hA: begin
        p.b    = a_in ^ m[1];
        p.b_oe = 1'b1;
      end
      default: begin
        p.sw_closed = m[1];
      end
    endcase
    return p;
  endfunction : pair_drive

  // ==========================================================================
  // synchronisers
  logic [2:0] sk_q;
  logic [1:0] cs_q;
  logic [1:0] di_q;
  logic [7:0] pad1_q;
  logic [7:0] pad2_q;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sk_q   <= 3'h0;
      cs_q   <= 2'h0;
      di_q   <= 2'h0;
      pad1_q <= 8'h00;
      pad2_q <= 8'h00;
    end else begin
      sk_q   <= {sk_q[1:0], serial_clock_line_i};
      cs_q   <= {cs_q[0], chip_select_i};
      di_q   <= {di_q[0], serial_in_pin_i};
      pad1_q <= out_pin_i;
      pad2_q <= pad1_q;
    end
  end

  wire sk_rise_w = sk_q[1] & ~sk_q[2];
  wire cs_w      = cs_q[1];
  wire di_w      = di_q[1];

  // ==========================================================================
  // serial front end
  seoc_pkg::seoc_state_e state_q;
  seoc_pkg::seoc_state_e state_d;
  logic [4:0]  cnt_q;
  logic [15:0] sh_q;
  logic [5:0]  addr_q;
  logic        fill_q;
  logic        we_q;
  logic        boot_q;
  logic [15:0] cfg_q;
  logic        so_q;
  logic [15:0] mem_q [seoc_pkg::WORDS];

  wire [7:0]  hdr_w     = {sh_q[6:0], di_w};
  wire [1:0]  hdr_op_w  = hdr_w[7:6];
  wire [5:0]  hdr_adr_w = hdr_w[5:0];
  wire [15:0] data_w    = {sh_q[14:0], di_w};
  wire        head_done = sk_rise_w && state_q == seoc_pkg::ST_HEAD && cnt_q == seoc_pkg::HDR_LAST;
  wire        data_done = sk_rise_w && state_q == seoc_pkg::ST_DATA && cnt_q == seoc_pkg::DATA_LAST;
  // last bit of a word on a continued read: the count restarts for the next word
  wire        rd_wrap_w = sk_rise_w && state_q == seoc_pkg::ST_READ && cnt_q == seoc_pkg::DATA_LAST;
  wire        commit_w  = data_done && we_q;
  wire        live_wr_w = commit_w && !fill_q && addr_q == seoc_pkg::LIVE_ADDR;
  wire        is_write  = hdr_op_w == seoc_pkg::OP_WRITE;
  wire        is_fill   = hdr_op_w == seoc_pkg::OP_EXT && hdr_adr_w[5:4] == seoc_pkg::EXT_FILL;
  wire [5:0]  next_adr  = addr_q + 6'h01;
  wire [15:0] stored_w  = mem_q[seoc_pkg::STORED_ADDR];

  function automatic logic [15:0] word_at(input logic [5:0] a, input logic [15:0] live, input logic [15:0] w);
    return (a == seoc_pkg::LIVE_ADDR) ? live : w;
  endfunction : word_at

  wire [15:0] rd_first_w = word_at(hdr_adr_w, cfg_q, mem_q[hdr_adr_w]);
  wire [15:0] rd_next_w  = word_at(next_adr, cfg_q, mem_q[next_adr]);

  always_comb begin
    state_d = state_q;
    if (!cs_w) begin
      state_d = seoc_pkg::ST_IDLE;
    end else if (sk_rise_w) begin
      case (state_q)
        seoc_pkg::ST_IDLE: state_d = di_w ? seoc_pkg::ST_HEAD : seoc_pkg::ST_IDLE;
        seoc_pkg::ST_HEAD: begin
          if (cnt_q == seoc_pkg::HDR_LAST) begin
            if (hdr_op_w == seoc_pkg::OP_READ) state_d = seoc_pkg::ST_READ;
            else if (is_write || is_fill) state_d = seoc_pkg::ST_DATA;
            else state_d = seoc_pkg::ST_HOLD;
          end
        end
        seoc_pkg::ST_DATA: state_d = (cnt_q == seoc_pkg::DATA_LAST) ? seoc_pkg::ST_HOLD : seoc_pkg::ST_DATA;
        seoc_pkg::ST_READ: state_d = seoc_pkg::ST_READ;
        seoc_pkg::ST_HOLD: state_d = seoc_pkg::ST_HOLD;
        default:           state_d = seoc_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= seoc_pkg::ST_IDLE;
      cnt_q   <= 5'h00;
      sh_q    <= 16'h0000;
      addr_q  <= 6'h00;
      fill_q  <= 1'b0;
      so_q    <= 1'b0;
    end else begin
      state_q <= state_d;
      if (!cs_w || head_done || data_done || rd_wrap_w || (sk_rise_w && state_q == seoc_pkg::ST_IDLE)) begin
        cnt_q <= 5'h00;
      end else if (sk_rise_w) begin
        cnt_q <= cnt_q + 5'h01;
      end
      if (!cs_w) begin
        so_q <= 1'b0;
      end else if (head_done) begin
        addr_q <= hdr_adr_w;
        fill_q <= is_fill;
        sh_q   <= (hdr_op_w == seoc_pkg::OP_READ) ? rd_first_w : 16'h0000;
      end else if (sk_rise_w && state_q == seoc_pkg::ST_READ) begin
        so_q <= sh_q[15];
        if (cnt_q == seoc_pkg::DATA_LAST) begin
          sh_q   <= rd_next_w;
          addr_q <= next_adr;
        end else begin
          sh_q <= {sh_q[14:0], 1'b0};
        end
      end else if (sk_rise_w && (state_q == seoc_pkg::ST_HEAD || state_q == seoc_pkg::ST_DATA)) begin
        sh_q <= data_w;
      end
    end
  end

  // ==========================================================================
  // write lock, live register and storage
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      we_q   <= seoc_pkg::WE_RESET;
      boot_q <= 1'b1;
      cfg_q  <= seoc_pkg::CFG_RESET;
    end else begin
      boot_q <= 1'b0;
      if (head_done && hdr_op_w == seoc_pkg::OP_EXT) begin
        if (hdr_adr_w[5:4] == seoc_pkg::EXT_UNLOCK) we_q <= 1'b1;
        else if (hdr_adr_w[5:4] == seoc_pkg::EXT_LOCK) we_q <= 1'b0;
      end
      if (boot_q) cfg_q <= stored_w;
      else if (live_wr_w) cfg_q <= data_w;
    end
  end

  // nonvolatile words keep their content through reset
  always_ff @(posedge sys_clk_i) begin
    for (int i = 0; i < seoc_pkg::WORDS; i++) begin
      if (commit_w && fill_q && i != int'(seoc_pkg::LIVE_ADDR)) mem_q[i] <= data_w;
    end
    if (commit_w && !fill_q && addr_q != seoc_pkg::LIVE_ADDR) mem_q[addr_q] <= data_w;
  end

  // ==========================================================================
  // output pairs
  seoc_pkg::seoc_pair_s pair_w [4];
  logic [7:0] pin_q;
  logic [7:0] oe_q;
  logic [3:0] sw_q;

  for (genvar n = 0; n < 4; n++) begin : g_pair
    assign pair_w[n] = pair_drive(cfg_q[4*n+3:4*n], pad2_q[2*n], pad2_q[2*n+1]);
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pin_q <= 8'h00;
      oe_q  <= 8'h00;
      sw_q  <= 4'h0;
    end else begin
      for (int n = 0; n < 4; n++) begin
        pin_q[2*n]   <= pair_w[n].a;
        pin_q[2*n+1] <= pair_w[n].b;
        oe_q[2*n]    <= pair_w[n].a_oe;
        oe_q[2*n+1]  <= pair_w[n].b_oe;
        sw_q[n]      <= pair_w[n].sw_closed;
      end
    end
  end

  assign out_pin_o              = pin_q;
  assign out_pin_oe_o           = oe_q;
  assign analog_switch_closed_o = sw_q;
  assign serial_out_o           = so_q;

  // ==========================================================================
  // checks
  // a stored word never written boots unknown, so the copy is compared case-exact
  a_boot_load: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      boot_q |=> cfg_q === $past(stored_w))
    else $error("live register not loaded from stored word");
  a_static_pair: assert property (@(posedge sys_clk_i) disable iff (rst_i || boot_q)
      cfg_q[3:2] == 2'h0 |=> oe_q[1:0] == 2'h3 && pin_q[0] == $past(cfg_q[1]) && pin_q[1] == $past(cfg_q[0]))
    else $error("static mode drives wrong levels");
  a_tri_mode: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      cfg_q[3:0] == 4'h4 |=> oe_q[1:0] == 2'h1 && !pin_q[0])
    else $error("tri-state mode wrong");
  a_analog_sw: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      cfg_q[3:2] == 2'h3 |=> oe_q[1:0] == 2'h0 && sw_q[0] == $past(cfg_q[1]))
    else $error("analog switch mode wrong");
  a_follow_pin: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      cfg_q[7:4] == 4'h5 |=> pin_q[2] == $past(pad2_q[3]) && oe_q[3:2] == 2'h1)
    else $error("follower mode wrong");
  a_lock_blocks: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      data_done && !we_q |=> $stable(cfg_q) && $stable(stored_w))
    else $error("locked write changed state");
  a_live_write: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      live_wr_w |=> cfg_q == $past(data_w) && stored_w == $past(stored_w))
    else $error("live write wrong or touched stored word");
  a_standby_idle: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      !cs_w |=> state_q == seoc_pkg::ST_IDLE && !so_q)
    else $error("standby not idle");
  a_read_shift: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      cs_w && sk_rise_w && state_q == seoc_pkg::ST_READ |=> so_q == $past(sh_q[15]))
    else $error("read bit not shifted on rising edge");

endmodule : seoc_core

// >>> design/seoc_pkg.sv
// constants, types and field layouts of the serial eeprom output configuration block
// assumes one system clock; all host pins arrive asynchronous to it
//
// Notes on behaviour
// - sixty general sixteen-bit words, each read and written on its own
// - words 61 and 62 hold output settings, not general data
// - each output drives static high or low; pairs may act as switches
// - a write lock makes every programming command do nothing
// - a word write completes by itself, no erase command needed first
// - host access only over serial clock, data in, data out and chip select
// - configuration register drives eight outputs as four pairs, four bits each
// - modes 0 to 3 drive both pins as static levels
// - modes 4, 7, 8, 11 drive one pin and float the other
// - top mode bits set select analog switch, open 12 and 13, closed 14 and 15
// - at power-up the configuration register loads from stored word 61
// - live register at 62; writing it changes outputs, word 61 untouched
// - live register values are lost at power-down, restored from 61
// - chip select low means standby: serial ignored, outputs still driven
// - read data bits change on the rising serial clock edge
// - start 1, opcode 2 bits, address 6 bits; read, write, lock commands
package seoc_pkg;

  // ==========================================================================
  // storage map
  localparam int          WORDS        = 64;
  localparam int          GENERAL      = 60;
  localparam logic [5:0]  STORED_ADDR  = 6'h3D;
  localparam logic [5:0]  LIVE_ADDR    = 6'h3E;

  // ==========================================================================
  // command fields
  localparam logic [1:0]  OP_READ      = 2'h2;
  localparam logic [1:0]  OP_WRITE     = 2'h1;
  localparam logic [1:0]  OP_EXT       = 2'h0;
  localparam logic [1:0]  EXT_UNLOCK   = 2'h3;
  localparam logic [1:0]  EXT_FILL     = 2'h1;
  localparam logic [1:0]  EXT_LOCK     = 2'h0;
  localparam logic [4:0]  HDR_LAST     = 5'h07;
  localparam logic [4:0]  DATA_LAST    = 5'h0F;

  // ==========================================================================
  // reset values
  localparam logic        WE_RESET     = 1'b0;
  localparam logic [15:0] CFG_RESET    = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HEAD = 3'b001,
    ST_DATA = 3'b010,
    ST_READ = 3'b011,
    ST_HOLD = 3'b100
  } seoc_state_e;

  // drive of one output pair
  typedef struct packed {
    logic a;
    logic a_oe;
    logic b;
    logic b_oe;
    logic sw_closed;
  } seoc_pair_s;

endpackage : seoc_pkg

// >>> sim/seoc_core_bench.sv
// self-checking bench of the output configuration block
// assumes the host model for all serial traffic and a resistive pad model on the outputs
`timescale 1ns/10ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin error_cnt++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module seoc_core_bench;
  // ==========================================================================
  // clock, reset and pins
  logic        sys_clk_i = 1'b0;
  logic        rst_i     = 1'b1;
  logic        sclk, cs, din, dout;
  logic [7:0]  ext       = 8'h5A;
  logic [7:0]  pad, pin_o, pin_oe;
  logic [3:0]  sw;
  logic [31:0] rd;
  logic [15:0] cfg;
  int          error_cnt = 0;
  int          n_checks  = 0;

  always #2.5 sys_clk_i = ~sys_clk_i;
  // undriven pins take the level of the outside load
  assign pad = (pin_o & pin_oe) | (ext & ~pin_oe);

  seoc_core DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .serial_clock_line_i(sclk), .chip_select_i(cs),
    .serial_in_pin_i(din), .serial_out_o(dout), .out_pin_i(pad), .out_pin_o(pin_o),
    .out_pin_oe_o(pin_oe), .analog_switch_closed_o(sw));
  seoc_host host (.sys_clk_i(sys_clk_i), .serial_out_i(dout), .serial_clock_line_o(sclk),
    .chip_select_o(cs), .serial_in_pin_o(din));

  // ==========================================================================
  // access tasks
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    host.xfer({1'b1, seoc_pkg::OP_WRITE, a, d}, 25, 0, 1'b1, rd);
  endtask : wr

  task automatic rdw(input logic [5:0] a, input int nr);
    host.xfer({16'h0000, 1'b1, seoc_pkg::OP_READ, a}, 9, nr, 1'b1, rd);
  endtask : rdw

  task automatic ext_cmd(input logic [1:0] c, input logic [15:0] d, input int nb);
    host.xfer({1'b1, seoc_pkg::OP_EXT, c, 4'h0, d} >> (25 - nb), nb, 0, 1'b1, rd);
  endtask : ext_cmd

  task automatic power_up();
    rst_i = 1'b1;
    repeat (5) @(posedge sys_clk_i);
    #1 rst_i = 1'b0;
    repeat (4) @(posedge sys_clk_i);
    #1;
  endtask : power_up

  function automatic seoc_pkg::seoc_pair_s exp_pair(input logic [3:0] m, input logic pa, input logic pb);
    seoc_pkg::seoc_pair_s p;
    p = '0;
    case (m)
      4'h0, 4'h1, 4'h2, 4'h3: p = '{m[1], 1'b1, m[0], 1'b1, 1'b0};
      4'h4, 4'h7: p = '{m[0], 1'b1, 1'b0, 1'b0, 1'b0};
      4'h8, 4'hB: p = '{1'b0, 1'b0, m[0], 1'b1, 1'b0};
      4'h5, 4'h6: p = '{pb ^ m[1], 1'b1, 1'b0, 1'b0, 1'b0};
      4'h9, 4'hA: p = '{1'b0, 1'b0, pa ^ m[1], 1'b1, 1'b0};
      default: p.sw_closed = m[1];
    endcase
    return p;
  endfunction : exp_pair

  task automatic chk_pins(input logic [15:0] c);
    seoc_pkg::seoc_pair_s p;
    logic [4:0]           g;
    for (int n = 0; n < 4; n++) begin
      p = exp_pair(c[4*n +: 4], ext[2*n], ext[2*n+1]);
      g = {pin_o[2*n] & pin_oe[2*n], pin_oe[2*n], pin_o[2*n+1] & pin_oe[2*n+1], pin_oe[2*n+1], sw[n]};
      `CHK(g, p)
    end
  endtask : chk_pins

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // ==========================================================================
  // tests
  initial begin
    // about three times the length of the whole test sequence
    #300000;
    error_cnt++;
    $display("Error at %0t: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    power_up();
    ext_cmd(seoc_pkg::EXT_UNLOCK, 16'h0000, 9);
    wr(6'h05, 16'h1111);
    wr(6'h06, 16'hEEEE);
    wr(seoc_pkg::STORED_ADDR, 16'h2310);
    wr(seoc_pkg::LIVE_ADDR, 16'hFFFF);
    chk_pins(16'hFFFF);
    ext_cmd(seoc_pkg::EXT_LOCK, 16'h0000, 9);
    wr(6'h05, 16'h2222);
    rdw(6'h05, 32);
    `CHK(rd, 32'h1111EEEE)
    power_up();
    chk_pins(16'h2310);
    rdw(seoc_pkg::STORED_ADDR, 32);
    `CHK(rd, 32'h23102310)
    wr(6'h05, 16'h3333);
    rdw(6'h05, 16);
    `CHK(rd[15:0], 16'h1111)
    ext_cmd(seoc_pkg::EXT_UNLOCK, 16'h0000, 9);
    for (int k = 0; k < 4; k++) begin
      cfg = {4'(4*k+3), 4'(4*k+2), 4'(4*k+1), 4'(4*k)};
      wr(seoc_pkg::LIVE_ADDR, cfg);
      chk_pins(cfg);
      ext = ~ext;
      repeat (8) @(posedge sys_clk_i);
      #1;
      chk_pins(cfg);
      ext = ~ext;
    end
    rdw(seoc_pkg::STORED_ADDR, 16);
    `CHK(rd[15:0], 16'h2310)
    host.xfer({1'b1, seoc_pkg::OP_WRITE, seoc_pkg::LIVE_ADDR, 16'h0000}, 25, 0, 1'b0, rd);
    chk_pins(cfg);
    `CHK(dout, 1'b0)
    ext_cmd(seoc_pkg::EXT_LOCK, 16'h0000, 9);
    wr(seoc_pkg::LIVE_ADDR, 16'h0000);
    chk_pins(cfg);
    ext_cmd(seoc_pkg::EXT_UNLOCK, 16'h0000, 9);
    ext_cmd(seoc_pkg::EXT_FILL, 16'hC3C3, 25);
    rdw(6'h3B, 32);
    `CHK(rd, 32'hC3C3C3C3)
    rdw(seoc_pkg::LIVE_ADDR, 16);
    `CHK(rd[15:0], cfg)
    power_up();
    chk_pins(16'hC3C3);
    wrap_up();
  end
endmodule : seoc_core_bench

// >>> sim/seoc_host.sv
// host model: drives the four-wire serial port in whole frames
// assumes the bench clock paces every pin change, 16 clocks per half period
`timescale 1ns/10ps
module seoc_host (
  // pacing clock
  input  wire logic sys_clk_i,
  // serial port
  input  wire logic serial_out_i,
  output logic      serial_clock_line_o,
  output logic      chip_select_o,
  output logic      serial_in_pin_o
);
  // ==========================================================================
  // idle levels
  initial begin
    serial_clock_line_o = 1'b0;
    chip_select_o       = 1'b0;
    serial_in_pin_o     = 1'b1;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : wait_clk

  // ==========================================================================
  // nb bits out msb first, then nr bits back; sel low runs the frame in standby
  task automatic xfer(input logic [24:0] bits, input int nb, input int nr, input logic sel,
                      output logic [31:0] rd);
    rd = '0;
    chip_select_o = sel;
    wait_clk(16);
    for (int i = nb - 1; i >= 0; i--) begin
      serial_in_pin_o = bits[i];
      wait_clk(16);
      serial_clock_line_o = 1'b1;
      wait_clk(16);
      serial_clock_line_o = 1'b0;
    end
    for (int i = 0; i < nr; i++) begin
      serial_in_pin_o = ~serial_in_pin_o;
      wait_clk(16);
      serial_clock_line_o = 1'b1;
      wait_clk(16);
      // sampled half a period after the shifting edge
      rd = {rd[30:0], serial_out_i};
      serial_clock_line_o = 1'b0;
    end
    wait_clk(16);
    chip_select_o = 1'b0;
    serial_in_pin_o = ~serial_in_pin_o;
    wait_clk(8);
  endtask : xfer
endmodule : seoc_host
